// >>> src/vlsp_consts.vh
`ifndef VLSP_CONSTS_VH
`define VLSP_CONSTS_VH

// ============================================================
// Line and frame timing.
`define VLSP_BLANK_CLKS 12'd280
`define VLSP_ACTIVE_BEATS 12'd1920
`define VLSP_LINES_PER_FRAME 5'd24
`define VLSP_FRAME_RATE_HZ 2700
`define VLSP_FRAME_CLKS 32'd55000
`define VLSP_FRAME_CLKS_DEFAULT 55000
`define VLSP_ONE_12 12'h001
`define VLSP_ONE_5 5'h01
`define VLSP_ONE_32 32'h00000001
`define VLSP_ZERO_12 12'h000
`define VLSP_ZERO_5 5'h00
`define VLSP_ZERO_32 32'h00000000

// ============================================================
// Stream data and buffer shape.
`define VLSP_DATA_W 32
`define VLSP_FIFO_DEPTH 32
`define VLSP_FIFO_AW 5
`define VLSP_PIXEL_SEED 32'h00000000
`define VLSP_PIXEL_STEP 32'h00000001

`endif

// >>> src/vlsp_fifo.v
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// Synchronous FIFO with valid and ready on both sides.
module vlsp_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW = 5
)
(
  // Clock and reset.
  input wire clk_i,
  input wire arst_n_i,
  // Fill side.
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  // Drain side.
  output reg [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW:0] wr_ptr_r;
  reg [AW:0] rd_ptr_r;
  reg [AW:0] count_r;
  reg out_valid_r;
  wire do_wr;
  wire do_rd;
  wire [AW:0] depth_c;

  assign depth_c = DEPTH[AW:0];
  assign in_ready_o = (count_r != depth_c);
  assign out_valid_o = out_valid_r;
  assign do_wr = in_valid_i & in_ready_o;
  // The output register is refilled when it is empty or being taken and the storage array holds at least one entry.
  assign do_rd = (count_r != {(AW+1){1'b0}}) & (~out_valid_r | out_ready_i);

  // Storage array, written on the fill side.
  always @(posedge clk_i)
  begin
    if (do_wr)
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
  end

  // Pointers, occupancy and registered read data.
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
      count_r <= {(AW+1){1'b0}};
      out_valid_r <= 1'b0;
      out_data_o <= {WIDTH{1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr_r <= wr_ptr_r + {{AW{1'b0}}, 1'b1};
      if (do_rd)
      begin
        rd_ptr_r <= rd_ptr_r + {{AW{1'b0}}, 1'b1};
        out_data_o <= mem_r[rd_ptr_r[AW-1:0]];
        out_valid_r <= 1'b1;
      end
      else if (out_ready_i)
        out_valid_r <= 1'b0;
      if (do_wr && !do_rd)
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      else if (!do_wr && do_rd)
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
    end
  end

endmodule // vlsp_fifo

`default_nettype wire

// >>> src/vlsp_pacer.v
`include "vlsp_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module vlsp_pacer #(
  parameter FRAME_CLKS = `VLSP_FRAME_CLKS_DEFAULT
)
(
  // Clock and reset.
  input wire SYS_CLK_I,
  input wire ARST_N_I,
  // Frame sync out.
  output reg FSYNC_O,
  // Write stream toward the DMA stream-to-memory port.
  output reg [31:0] WR_TDATA_O,
  output reg WR_TVALID_O,
  output reg WR_TLAST_O,
  input wire WR_TREADY_I,
  // Read stream from the DMA memory-to-stream port.
  input wire [31:0] RD_TDATA_I,
  input wire RD_TVALID_I,
  input wire RD_TLAST_I,
  output reg RD_TREADY_O,
  // Received pixels out of the buffer.
  output reg [31:0] PIX_DATA_O,
  output reg PIX_VALID_O,
  output reg PIX_LAST_O,
  input wire PIX_READY_I,
  // Status.
  output reg WR_THROTTLE_O,
  output reg RD_THROTTLE_O,
  output reg RD_LAST_ERR_O,
  output reg LINE_BUSY_O,
  output reg [4:0] LINE_NUM_O
);

  // ============================================================
  // Line state machine codes.
  localparam ST_WAIT = 2'b00;
  localparam ST_BLANK = 2'b01;
  localparam ST_ACTIVE = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [31:0] frame_cnt_r;
  reg fsync_r;
  reg [11:0] blank_cnt_r;
  reg [11:0] beat_cnt_r;
  reg [4:0] line_cnt_r;
  reg [31:0] pixel_r;
  wire [31:0] frame_len;
  wire line_start;
  wire blank_done;
  wire line_end;
  wire fifo_in_ready;
  wire [32:0] fifo_out_data;
  wire fifo_out_valid;
  wire pix_take;

  assign frame_len = FRAME_CLKS;

  // Counter step helper shared by the blanking and beat counters.
  function [11:0] vlsp_inc12;
    input [11:0] v;
    begin
      vlsp_inc12 = v + `VLSP_ONE_12;
    end
  endfunction

  // ============================================================
  // Frame sync generator: one pulse per frame period.
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      frame_cnt_r <= `VLSP_ZERO_32;
      fsync_r <= 1'b0;
    end
    else
    begin
      fsync_r <= (frame_cnt_r == frame_len - `VLSP_ONE_32);
      if (frame_cnt_r == frame_len - `VLSP_ONE_32)
        frame_cnt_r <= `VLSP_ZERO_32;
      else
        frame_cnt_r <= frame_cnt_r + `VLSP_ONE_32;
    end
  end

  // ============================================================
  // Line sequencing.
  assign line_start = fsync_r;
  assign blank_done = (blank_cnt_r == `VLSP_BLANK_CLKS - `VLSP_ONE_12);
  // A beat counts only when the write side is accepted; the read side is
  // paced by the same window and its own throttle is flagged separately.
  assign line_end = (beat_cnt_r == `VLSP_ACTIVE_BEATS - `VLSP_ONE_12) &
                    WR_TREADY_I;

  // Next state of the line machine.
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_WAIT:
        if (line_start)
          state_nxt = ST_BLANK;
      ST_BLANK:
        if (blank_done)
          state_nxt = ST_ACTIVE;
      ST_ACTIVE:
        if (line_end)
        begin
          if (line_cnt_r == `VLSP_LINES_PER_FRAME - `VLSP_ONE_5)
            state_nxt = ST_WAIT;
          else
            state_nxt = ST_BLANK;
        end
      default:
        state_nxt = ST_WAIT;
    endcase
  end

  // Counters for blanking, beats and lines.
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      state_r <= ST_WAIT;
      blank_cnt_r <= `VLSP_ZERO_12;
      beat_cnt_r <= `VLSP_ZERO_12;
      line_cnt_r <= `VLSP_ZERO_5;
      pixel_r <= `VLSP_PIXEL_SEED;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == ST_BLANK)
        blank_cnt_r <= blank_done ? `VLSP_ZERO_12 : vlsp_inc12(blank_cnt_r);
      else
        blank_cnt_r <= `VLSP_ZERO_12;
      if (state_r == ST_ACTIVE && WR_TREADY_I)
      begin
        beat_cnt_r <= line_end ? `VLSP_ZERO_12 : vlsp_inc12(beat_cnt_r);
        pixel_r <= pixel_r + `VLSP_PIXEL_STEP;
      end
      if (state_r == ST_WAIT && line_start)
        line_cnt_r <= `VLSP_ZERO_5;
      else if (state_r == ST_ACTIVE && line_end)
        line_cnt_r <= line_cnt_r + `VLSP_ONE_5;
    end
  end

  // ============================================================
  // Registered stream and status outputs.
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      FSYNC_O <= 1'b0;
      WR_TDATA_O <= `VLSP_ZERO_32;
      WR_TVALID_O <= 1'b0;
      WR_TLAST_O <= 1'b0;
      RD_TREADY_O <= 1'b0;
      WR_THROTTLE_O <= 1'b0;
      RD_THROTTLE_O <= 1'b0;
      RD_LAST_ERR_O <= 1'b0;
      LINE_BUSY_O <= 1'b0;
      LINE_NUM_O <= `VLSP_ZERO_5;
    end
    else
    begin
      FSYNC_O <= fsync_r;
      LINE_BUSY_O <= (state_nxt == ST_ACTIVE);
      LINE_NUM_O <= line_cnt_r;
      // Source holds valid through the active window.
      if (state_nxt == ST_ACTIVE)
      begin
        WR_TVALID_O <= 1'b1;
        if (state_r != ST_ACTIVE || line_end)
          WR_TDATA_O <= pixel_r;
        else if (WR_TREADY_I)
          WR_TDATA_O <= pixel_r + `VLSP_PIXEL_STEP;
      end
      else
        WR_TVALID_O <= 1'b0;
      // Last beat flag for beat 1920.
      if (state_nxt != ST_ACTIVE)
        WR_TLAST_O <= 1'b0;
      else if (state_r != ST_ACTIVE)
        WR_TLAST_O <= 1'b0;
      else if (WR_TREADY_I)
        WR_TLAST_O <= (beat_cnt_r == `VLSP_ACTIVE_BEATS - 12'd2);
      // Sink is ready only in the active window and when the buffer had room on the clock before.
      RD_TREADY_O <= (state_nxt == ST_ACTIVE) & fifo_in_ready;
      // Throttle flags, one-cycle pulses sampled per active clock.
      WR_THROTTLE_O <= (state_r == ST_ACTIVE) & WR_TVALID_O &
                       ~WR_TREADY_I;
      RD_THROTTLE_O <= (state_r == ST_ACTIVE) & RD_TREADY_O &
                       ~RD_TVALID_I;
      // tlast from the DMA must land on beat 1920 of the source.
      RD_LAST_ERR_O <= RD_TREADY_O & RD_TVALID_I &
                       (RD_TLAST_I != WR_TLAST_O);
    end
  end

  // ============================================================
  // Receive buffer between the read stream and the pixel port.
  vlsp_fifo #(
    .WIDTH(`VLSP_DATA_W + 1),
    .DEPTH(`VLSP_FIFO_DEPTH),
    .AW(`VLSP_FIFO_AW)
  ) u_rx_fifo (
    .clk_i(SYS_CLK_I),
    .arst_n_i(ARST_N_I),
    .in_data_i({RD_TLAST_I, RD_TDATA_I}),
    .in_valid_i(RD_TVALID_I & RD_TREADY_O),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pix_take)
  );

  // Output stage: a register slice so the pixel port comes from flops.
  assign pix_take = ~PIX_VALID_O | PIX_READY_I;

  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      PIX_DATA_O <= `VLSP_ZERO_32;
      PIX_VALID_O <= 1'b0;
      PIX_LAST_O <= 1'b0;
    end
    else if (pix_take)
    begin
      PIX_VALID_O <= fifo_out_valid;
      PIX_DATA_O <= fifo_out_data[31:0];
      PIX_LAST_O <= fifo_out_data[32];
    end
  end

endmodule // vlsp_pacer

`default_nettype wire

// >>> bench/vlsp_pacer_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Port checker for the line pacer.
module vlsp_pacer_chk #(
  parameter FRAME_CLKS = 55000
)
(
  // Clock, reset and sync.
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  input wire logic FSYNC_O,
  // Streams and status.
  input wire logic [31:0] WR_TDATA_O,
  input wire logic WR_TVALID_O,
  input wire logic WR_TLAST_O,
  input wire logic WR_TREADY_I,
  input wire logic RD_TVALID_I,
  input wire logic RD_TREADY_O,
  input wire logic WR_THROTTLE_O,
  input wire logic RD_THROTTLE_O,
  input wire logic LINE_BUSY_O,
  input wire logic [4:0] LINE_NUM_O
);
  reg [15:0] gap_r;
  reg [10:0] beat_r;
  reg [31:0] fcnt_r;
  reg seen_r;
  // Counts blank clocks, accepted beats and clocks between syncs.
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
    if (!ARST_N_I)
    begin
      gap_r <= 16'h0000;
      beat_r <= 11'h000;
      fcnt_r <= 32'h00000000;
      seen_r <= 1'b0;
    end
    else
    begin
      gap_r <= WR_TVALID_O ? 16'h0000 : (FSYNC_O ? 16'h0001 : gap_r + 1);
      if (WR_TVALID_O && WR_TREADY_I)
        beat_r <= WR_TLAST_O ? 11'h000 : beat_r + 1;
      fcnt_r <= FSYNC_O ? 32'h00000001 : fcnt_r + 1;
      seen_r <= seen_r | FSYNC_O;
    end
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  sync_pulse_a: assert property (FSYNC_O |=> !FSYNC_O)
    else $error("sync pulse too wide");
  sync_period_a: assert property (FSYNC_O && seen_r |-> fcnt_r == FRAME_CLKS)
    else $error("sync period wrong");
  blank_gap_a: assert property ($rose(WR_TVALID_O) |-> gap_r == 16'h0118)
    else $error("blank length wrong");
  rd_window_a: assert property (RD_TREADY_O |-> LINE_BUSY_O)
    else $error("read ready outside line");
  last_beat_a: assert property (WR_TVALID_O && WR_TREADY_I && WR_TLAST_O |-> beat_r == 11'h77F)
    else $error("last not on final beat");
  beat_hold_a: assert property (WR_TVALID_O && !WR_TREADY_I |=> WR_TVALID_O && $stable(WR_TDATA_O))
    else $error("stalled beat changed");
  wr_throttle_a: assert property (WR_TVALID_O && !WR_TREADY_I |=> WR_THROTTLE_O)
    else $error("write throttle missed");
  rd_throttle_a: assert property (RD_TREADY_O && !RD_TVALID_I |-> ##[0:1] RD_THROTTLE_O)
    else $error("read throttle missed");
  frame_stop_a: assert property (LINE_NUM_O == 5'h18 |-> !WR_TVALID_O && !RD_TREADY_O)
    else $error("line after frame end");
endmodule // vlsp_pacer_chk
bind vlsp_pacer vlsp_pacer_chk #(.FRAME_CLKS(FRAME_CLKS)) i_chk (
  .SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I), .FSYNC_O(FSYNC_O),
  .WR_TDATA_O(WR_TDATA_O), .WR_TVALID_O(WR_TVALID_O),
  .WR_TLAST_O(WR_TLAST_O), .WR_TREADY_I(WR_TREADY_I),
  .RD_TVALID_I(RD_TVALID_I), .RD_TREADY_O(RD_TREADY_O),
  .WR_THROTTLE_O(WR_THROTTLE_O), .RD_THROTTLE_O(RD_THROTTLE_O),
  .LINE_BUSY_O(LINE_BUSY_O), .LINE_NUM_O(LINE_NUM_O));
`default_nettype wire

// >>> bench/vlsp_dma_model.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Stream ports of the DMA on the far side.
module vlsp_dma_model
(
  // Clock, reset and test controls.
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic stall_i,
  input wire logic gap_i,
  // Write sink and read source.
  output logic wr_tready_o,
  output logic [31:0] rd_tdata_o,
  output logic rd_tvalid_o,
  output logic rd_tlast_o,
  input wire logic rd_tready_i
);
  logic [10:0] cnt_r;
  logic [31:0] last_r;
  // Write side is ready ahead of sync unless told to stall.
  assign wr_tready_o = !stall_i;
  // Read data is the beat index; a gap shows inverted old data.
  assign rd_tvalid_o = !gap_i;
  assign rd_tlast_o = rd_tvalid_o && cnt_r == 11'h77F;
  assign rd_tdata_o = rd_tvalid_o ? {21'h000000, cnt_r} : ~last_r;
  // Beat counter wraps at the end of each line.
  always @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      cnt_r <= 11'h000;
      last_r <= 32'h00000000;
    end
    else if (rd_tvalid_o && rd_tready_i)
    begin
      cnt_r <= rd_tlast_o ? 11'h000 : cnt_r + 1;
      last_r <= rd_tdata_o;
    end
endmodule // vlsp_dma_model
`default_nettype wire

// >>> bench/vlsp_pacer_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Self-checking bench for the line pacer.
module vlsp_pacer_tb;
  localparam int FRAME = 53000;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic pix_rdy = 1'b1;
  logic stall = 1'b0;
  logic gap = 1'b0;
  logic fs, wv, wl, wr, rv, rl, rr, pv, pl, wt, rt, busy;
  logic [31:0] wd, rd, pd;
  logic [4:0] ln;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int t_sync, n;
  vlsp_pacer #(.FRAME_CLKS(FRAME)) i_dut (.SYS_CLK_I(clk),
    .ARST_N_I(arst_n), .FSYNC_O(fs), .WR_TDATA_O(wd), .WR_TVALID_O(wv),
    .WR_TLAST_O(wl), .WR_TREADY_I(wr), .RD_TDATA_I(rd), .RD_TVALID_I(rv),
    .RD_TLAST_I(rl), .RD_TREADY_O(rr), .PIX_DATA_O(pd), .PIX_VALID_O(pv),
    .PIX_LAST_O(pl), .PIX_READY_I(pix_rdy), .WR_THROTTLE_O(wt),
    .RD_THROTTLE_O(rt), .RD_LAST_ERR_O(), .LINE_BUSY_O(busy),
    .LINE_NUM_O(ln));
  vlsp_dma_model i_dma (.clk_i(clk), .arst_n_i(arst_n), .stall_i(stall),
    .gap_i(gap), .wr_tready_o(wr), .rd_tdata_o(rd), .rd_tvalid_o(rv),
    .rd_tlast_o(rl), .rd_tready_i(rr));
  // Clock and cycle count.
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  task give_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=0x%0h exp=0x%0h", $time, got, exp);
    end
  endtask
  // Waits on a selected condition, counting falling edges.
  task wait_on(input int s, input int lim);
    n = 0;
    while ((s == 0 ? fs : s == 1 ? wv : s == 2 ? !rr : s == 3 ? !pv :
      ln == 5'h18) !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > lim)
      begin
        chk(s, 32'hFFFF);
        give_verdict;
      end
    end
  endtask
  task t_first_line;
    int np, nw, hit;
    np = 0;
    nw = 0;
    hit = 0;
    wait_on(0, 60000);
    t_sync = cyc;
    wait_on(1, 400);
    chk(n, 280);
    chk(rr, 1);
    for (int i = 0; i < 3000 && hit != 3; i++)
    begin
      if (wv && wr)
      begin
        nw++;
        hit |= wl;
      end
      if (pv && pix_rdy)
      begin
        chk(pd, np);
        np++;
        hit |= {pl, 1'b0};
      end
      if (i == 9)
        chk(wt, 1);
      stall = (i == 8);
      @(negedge clk);
    end
    chk(nw, 1920);
    chk(np, 1920);
    $display("test first line done");
  endtask
  task t_read_stress;
    int seen;
    seen = 0;
    wait_on(1, 3000);
    gap = 1'b1;
    repeat (2)
    begin
      @(negedge clk);
      seen |= rt;
    end
    chk(seen, 1);
    gap = 1'b0;
    pix_rdy = 1'b0;
    wait_on(2, 60);
    chk(pv, 1);
    pix_rdy = 1'b1;
    wait_on(3, 3000);
    $display("test read stress done");
  endtask
  task t_frame_end;
    int bad, k;
    bad = 0;
    k = 0;
    wait_on(4, 60000);
    // Idle gap until the next sync, bounded so a lost sync cannot hang.
    while (fs !== 1'b1 && k < 3000)
    begin
      bad += wv | rr;
      k++;
      @(negedge clk);
    end
    chk(fs, 1);
    chk(bad, 0);
    chk(cyc - t_sync, FRAME);
    $display("test frame end done");
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    chk({fs, wv, rr}, 0);
    arst_n = 1'b1;
    t_first_line;
    t_read_stress;
    t_frame_end;
    give_verdict;
  end
endmodule // vlsp_pacer_tb
`default_nettype wire
